// ---- src/host_link_watchdog_safe_state.v ----
// link watchdog with latched safe state and axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "host_link_watchdog_map.vh"

// What this block does
// - watchdog off until enabled, trips after wait
// - trip stops normal processing, enters safe state
// - safe state switches outputs and relays off
// - safe state puts pwm outputs high impedance
// - safe entry saves retain data if enabled
// - safe state blinks indicator by error cause
// - safe state latched until power cycle
// - too early transfers get rejected
// - no exchange without link enable high
// - nothing driven until first host command
module host_link_watchdog_safe_state #(
  parameter MS_CYCLES = `MS_US * `CLK_MHZ,
  parameter MIN_SMALL_CYCLES = `MIN_CYCLE_SMALL_US * `CLK_MHZ,
  parameter MIN_LARGE_CYCLES = `MIN_CYCLE_LARGE_US * `CLK_MHZ
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write channels
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read channels
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // host link pins
  input wire host_link_enable,
  input wire link_sclk,
  input wire link_cs_n,
  // field outputs
  output wire [7:0] dout,
  output wire [3:0] relay,
  output wire pwm_out,
  output wire pwm_oe,
  output reg status_indicator,
  output reg retain_save,
  output wire safe_state,
  output wire irq
);

  // ---- registers ----
  reg [3:0] ctrl_reg;
  reg [15:0] timeout_reg;
  reg [12:0] outputs_reg;
  reg [7:0] duty_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;
  reg safe_reg;
  reg cmd_seen_reg;
  reg [1:0] cause_reg;
  reg [7:0] frame_cnt_reg;

  // ---- axi handshake state ----
  reg aw_held_reg;
  reg w_held_reg;
  reg [4:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg arready_reg;

  // merge byte lanes of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // a write completes once address and data are both held
  wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [31:0] wr_word_ctrl = merge({28'h0, ctrl_reg}, wdata_reg, wstrb_reg);
  wire [31:0] wr_word_to = merge({16'h0, timeout_reg}, wdata_reg, wstrb_reg);
  wire [31:0] wr_word_out = merge({19'h0, outputs_reg}, wdata_reg, wstrb_reg);
  wire [31:0] wr_word_duty = merge({24'h0, duty_reg}, wdata_reg, wstrb_reg);
  wire [31:0] wr_word_mask = merge({29'h0, irq_mask_reg}, wdata_reg,
    wstrb_reg);
  wire rd_fire = s_axi_arvalid && arready_reg;
  wire rd_irq = rd_fire && (s_axi_araddr == `ADDR_IRQ_STATUS);

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = arready_reg;

  // write side: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (waddr_reg)
          `ADDR_CTRL, `ADDR_WD_TIMEOUT, `ADDR_OUTPUTS, `ADDR_PWM_DUTY,
          `ADDR_IRQ_MASK: s_axi_bresp <= `AXI_OKAY;
          default: s_axi_bresp <= `AXI_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read side: one read at a time, answer one cycle after address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AXI_OKAY;
    end
    else if (rd_fire)
    begin
      arready_reg <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AXI_OKAY;
      case (s_axi_araddr)
        `ADDR_CTRL: s_axi_rdata <= {28'h0, ctrl_reg};
        `ADDR_WD_TIMEOUT: s_axi_rdata <= {16'h0, timeout_reg};
        `ADDR_OUTPUTS: s_axi_rdata <= {19'h0, outputs_reg};
        `ADDR_PWM_DUTY: s_axi_rdata <= {24'h0, duty_reg};
        `ADDR_STATUS: s_axi_rdata <= {16'h0, frame_cnt_reg, 4'h0,
          cause_reg, cmd_seen_reg, safe_reg};
        `ADDR_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_status_reg};
        `ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_reg};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ---- link pin synchronisers ----
  // first stage feeds only the second; edges come from stages two and three
  reg [2:0] sclk_sync_reg;
  reg [2:0] cs_sync_reg;
  reg [1:0] en_sync_reg;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
      en_sync_reg <= 2'h0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link_sclk};
      cs_sync_reg <= {cs_sync_reg[1:0], link_cs_n};
      en_sync_reg <= {en_sync_reg[0], host_link_enable};
    end
  end
  wire link_en = en_sync_reg[1];
  wire sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  wire cs_fall = !cs_sync_reg[1] && cs_sync_reg[2];
  wire cs_rise = cs_sync_reg[1] && !cs_sync_reg[2];

  // ---- millisecond enable divider ----
  reg [16:0] ms_div_reg;
  wire ms_tick = (ms_div_reg == MS_CYCLES[16:0] - 17'h1);
  always @(posedge aclk)
  begin
    if (!aresetn || ms_tick)
      ms_div_reg <= 17'h0;
    else
      ms_div_reg <= ms_div_reg + 17'h1;
  end

  // ---- frame tracking ----
  // the spacing counter runs from one frame start to the next and
  // saturates, so a long idle link never wraps into a false early start
  reg [17:0] gap_cnt_reg;
  reg in_frame_reg;
  reg early_reg;
  reg first_reg;
  reg [15:0] bits_reg;
  wire [17:0] min_gap = ctrl_reg[`CTRL_SMALL] ? MIN_SMALL_CYCLES[17:0]
    : MIN_LARGE_CYCLES[17:0];
  wire frame_end = in_frame_reg && cs_rise;
  wire frame_good = (bits_reg != 16'h0) && (bits_reg[2:0] == 3'h0);
  wire frame_ok = frame_end && frame_good && !early_reg && !safe_reg;
  wire frame_rej = frame_end && !frame_ok;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_cnt_reg <= 18'h0;
      in_frame_reg <= 1'b0;
      early_reg <= 1'b0;
      first_reg <= 1'b1;
      bits_reg <= 16'h0;
    end
    else
    begin
      if (gap_cnt_reg != 18'h3ffff)
        gap_cnt_reg <= gap_cnt_reg + 18'h1;
      if (cs_fall && link_en)
      begin
        in_frame_reg <= 1'b1;
        early_reg <= !first_reg && (gap_cnt_reg < min_gap);
        first_reg <= 1'b0;
        gap_cnt_reg <= 18'h0;
        bits_reg <= 16'h0;
      end
      else if (in_frame_reg)
      begin
        if (!link_en)
          in_frame_reg <= 1'b0;
        else if (cs_rise)
          in_frame_reg <= 1'b0;
        else if (sclk_rise && bits_reg != 16'hffff)
          bits_reg <= bits_reg + 16'h1;
      end
    end
  end

  // ---- watchdog and latched safe state ----
  reg [15:0] wd_cnt_reg;
  wire wd_run = ctrl_reg[`CTRL_WD_EN] && !safe_reg;
  wire trip = wd_run && ms_tick && (wd_cnt_reg >= timeout_reg);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wd_cnt_reg <= 16'h0;
      safe_reg <= 1'b0;
      cause_reg <= `CAUSE_NONE;
      retain_save <= 1'b0;
      cmd_seen_reg <= 1'b0;
      frame_cnt_reg <= 8'h0;
    end
    else
    begin
      retain_save <= 1'b0;
      if (!wd_run || frame_ok)
        wd_cnt_reg <= 16'h0;
      else if (ms_tick)
        wd_cnt_reg <= wd_cnt_reg + 16'h1;
      if (trip)
      begin
        safe_reg <= 1'b1;
        cause_reg <= link_en ? `CAUSE_SILENT : `CAUSE_LINK_OFF;
        retain_save <= ctrl_reg[`CTRL_RETAIN_EN];
      end
      if (frame_ok)
      begin
        cmd_seen_reg <= 1'b1;
        frame_cnt_reg <= frame_cnt_reg + 8'h1;
      end
    end
  end

  // ---- software registers and sticky interrupt bits ----
  // a read of the status word clears it, but a same-cycle event survives
  wire [2:0] irq_set = {trip, frame_rej, frame_ok};
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= `CTRL_RESET;
      timeout_reg <= `WD_TIMEOUT_RESET;
      outputs_reg <= 13'h0;
      duty_reg <= 8'h0;
      irq_mask_reg <= 3'h0;
      irq_status_reg <= 3'h0;
    end
    else
    begin
      if (wr_fire)
      begin
        case (waddr_reg)
          `ADDR_CTRL: ctrl_reg <= wr_word_ctrl[3:0];
          `ADDR_WD_TIMEOUT: timeout_reg <= wr_word_to[15:0];
          `ADDR_OUTPUTS: outputs_reg <= wr_word_out[12:0];
          `ADDR_PWM_DUTY: duty_reg <= wr_word_duty[7:0];
          `ADDR_IRQ_MASK: irq_mask_reg <= wr_word_mask[2:0];
          default: ;
        endcase
      end
      irq_status_reg <= (rd_irq ? 3'h0 : irq_status_reg) | irq_set;
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ---- pwm generator ----
  reg [7:0] pwm_cnt_reg;
  reg pwm_q_reg;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_cnt_reg <= 8'h0;
      pwm_q_reg <= 1'b0;
    end
    else
    begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h1;
      pwm_q_reg <= (pwm_cnt_reg < duty_reg);
    end
  end

  // ---- field output gating ----
  // off before the first accepted frame and from the trip edge on
  wire live = cmd_seen_reg && !safe_reg && !trip;
  reg [7:0] dout_reg;
  reg [3:0] relay_reg;
  reg pwm_oe_reg;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dout_reg <= 8'h0;
      relay_reg <= 4'h0;
      pwm_oe_reg <= 1'b0;
    end
    else
    begin
      dout_reg <= live ? outputs_reg[7:0] : 8'h0;
      relay_reg <= live ? outputs_reg[11:8] : 4'h0;
      pwm_oe_reg <= live && outputs_reg[`OUT_PWM_EN];
    end
  end
  assign dout = dout_reg;
  assign relay = relay_reg;
  assign pwm_oe = pwm_oe_reg;
  assign pwm_out = pwm_oe_reg & pwm_q_reg;
  assign safe_state = safe_reg;

  // ---- status indicator blink ----
  // half period is the cause times a base slot, so the pattern names
  // the fault without any shared timing with the host
  reg [9:0] led_ms_reg;
  reg [1:0] led_slot_reg;
  wire led_slot = ms_tick && (led_ms_reg == `LED_HALF_MS - 10'h1);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_ms_reg <= 10'h0;
      led_slot_reg <= 2'h0;
      status_indicator <= 1'b0;
    end
    else
    begin
      if (led_slot)
        led_ms_reg <= 10'h0;
      else if (ms_tick)
        led_ms_reg <= led_ms_reg + 10'h1;
      if (!safe_reg || !ctrl_reg[`CTRL_LED_EN])
      begin
        status_indicator <= 1'b0;
        led_slot_reg <= 2'h0;
      end
      else if (led_slot)
      begin
        if (led_slot_reg + 2'h1 >= cause_reg)
        begin
          led_slot_reg <= 2'h0;
          status_indicator <= !status_indicator;
        end
        else
          led_slot_reg <= led_slot_reg + 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/host_link_watchdog_map.vh ----
// register map, field positions and timing constants of the link watchdog
`ifndef HOST_LINK_WATCHDOG_MAP_VH
`define HOST_LINK_WATCHDOG_MAP_VH
// register byte addresses
`define ADDR_CTRL 5'h00
`define ADDR_WD_TIMEOUT 5'h04
`define ADDR_OUTPUTS 5'h08
`define ADDR_PWM_DUTY 5'h0c
`define ADDR_STATUS 5'h10
`define ADDR_IRQ_STATUS 5'h14
`define ADDR_IRQ_MASK 5'h18
// control register fields
`define CTRL_WD_EN 0
`define CTRL_RETAIN_EN 1
`define CTRL_LED_EN 2
`define CTRL_SMALL 3
// outputs register fields
`define OUT_DOUT_LSB 0
`define OUT_RELAY_LSB 8
`define OUT_PWM_EN 12
// interrupt bits
`define IRQ_FRAME_OK 0
`define IRQ_FRAME_REJ 1
`define IRQ_TRIP 2
// trip causes
`define CAUSE_NONE 2'h0
`define CAUSE_LINK_OFF 2'h1
`define CAUSE_SILENT 2'h2
// reset values
`define CTRL_RESET 4'h4
`define WD_TIMEOUT_RESET 16'h0064
// timing: clock rate and times in their own units
`define CLK_MHZ 25
`define MS_US 1000
`define MIN_CYCLE_SMALL_US 2500
`define MIN_CYCLE_LARGE_US 5000
`define LED_HALF_MS 10'h0fa
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ---- sim/host_link_watchdog_checker.sv ----
// checker of the safe state behaviour at the field pins
`timescale 1ns/10ps
`default_nettype none
module host_link_watchdog_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link pins
  input wire logic host_link_enable,
  input wire logic link_cs_n,
  // field outputs
  input wire logic [7:0] dout,
  input wire logic [3:0] relay,
  input wire logic pwm_out,
  input wire logic pwm_oe,
  input wire logic status_indicator,
  input wire logic retain_save,
  input wire logic safe_state
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic cmd_reg;
  // set early on any selected frame, so it never lags the design
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmd_reg <= 1'b0;
    else if (host_link_enable && !link_cs_n)
      cmd_reg <= 1'b1;
  end
  safe_off_a:
    assert property (safe_state |-> dout == 8'h00 && relay == 4'h0)
    else $error("outputs driven in safe state");
  pwm_hiz_a:
    assert property (safe_state |-> !pwm_oe && !pwm_out)
    else $error("pwm driven in safe state");
  safe_frozen_a:
    assert property (safe_state |=> $stable({dout, relay, pwm_oe}))
    else $error("outputs moved in safe state");
  safe_latch_a:
    assert property (safe_state |=> safe_state)
    else $error("safe state left");
  retain_entry_a:
    assert property (retain_save |-> ##[0:1] safe_state)
    else $error("retain save outside safe entry");
  retain_once_a:
    assert property (retain_save |=> !retain_save [*8])
    else $error("retain save repeated");
  led_dark_a:
    assert property (!safe_state |-> !status_indicator)
    else $error("indicator lit outside safe state");
  quiet_start_a:
    assert property (!cmd_reg |-> {dout, relay, pwm_oe} == 13'h0)
    else $error("outputs before first command");
  cover property ($rose(safe_state));
  cover property (retain_save);
  cover property ($rose(status_indicator));
endmodule
bind host_link_watchdog_safe_state host_link_watchdog_checker chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .host_link_enable(host_link_enable),
  .link_cs_n(link_cs_n),
  .dout(dout),
  .relay(relay),
  .pwm_out(pwm_out),
  .pwm_oe(pwm_oe),
  .status_indicator(status_indicator),
  .retain_save(retain_save),
  .safe_state(safe_state)
);
`default_nettype wire

// ---- sim/host_link_master_model.sv ----
// behavioural host driving the serial link pins
`timescale 1ns/10ps
`default_nettype none
module host_link_master_model #(
  parameter int HALF_NS = 160,
  parameter int GAP_NS = 4000 // scaled stand-in for the host cycle
) (
  // link pins
  output logic host_link_enable,
  output logic link_sclk,
  output logic link_cs_n
);
  // clock rests low and select high between frames
  initial
  begin
    host_link_enable = 1'b0;
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
  end
  // enable is set before a frame is begun
  task automatic set_en(input logic en);
    #3;
    host_link_enable = en;
  endtask
  // one frame at the link rate, then the minimum cycle unless early
  task automatic frame(input int bits, input logic early);
    #7;
    link_cs_n = 1'b0;
    repeat (bits)
    begin
      #HALF_NS link_sclk = 1'b1;
      #HALF_NS link_sclk = 1'b0;
    end
    #HALF_NS link_cs_n = 1'b1;
    #HALF_NS;
    if (!early)
      #GAP_NS;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_host_link_watchdog_safe_state.sv ----
// self-checking bench of the link watchdog
`timescale 1ns/10ps
`default_nettype none
`include "host_link_watchdog_map.vh"
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("mismatch at %0t: %h not %h", $time, g, e); \
    end \
  end
module tb_host_link_watchdog_safe_state;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, retain_seen = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, rnd;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic link_en, sclk, cs_n, pwm_out, pwm_oe, led, retain, safe;
  logic [7:0] dout;
  logic [3:0] relay;
  logic [33:0] exp_r[$], e;
  logic [1:0] exp_b[$];
  int failures = 0, n_tests = 0, cyc = 0, n;
  always #20 aclk = ~aclk;
  host_link_watchdog_safe_state #(.MS_CYCLES(20), .MIN_SMALL_CYCLES(50),
    .MIN_LARGE_CYCLES(100)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_link_enable(link_en),
    .link_sclk(sclk), .link_cs_n(cs_n), .dout(dout), .relay(relay),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .status_indicator(led),
    .retain_save(retain), .safe_state(safe), .irq(irq));
  host_link_master_model host (.host_link_enable(link_en),
    .link_sclk(sclk), .link_cs_n(cs_n));
  // answers are matched to the oldest note; a hang ends the run
  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      e = exp_r.pop_front();
      `CHK({rresp, rdata}, e)
    end
    if (bvalid && bready)
    begin
      e = {32'h0, exp_b.pop_front()};
      `CHK({32'h0, bresp}, e)
    end
    if (retain)
      retain_seen <= 1'b1;
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      summarize();
    end
  end
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {`AXI_OKAY, d};
  endfunction
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [33:0] x);
    exp_r.push_back(x);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    rnd = $urandom(32'h2039);
    rnd = $urandom();
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ADDR_CTRL, ok(32'h4));
    rd(`ADDR_WD_TIMEOUT, ok(32'h64));
    rd(5'h1c, {`AXI_SLVERR, 32'h0});
    wr(`ADDR_STATUS, 32'h1, `AXI_SLVERR);
    wr(`ADDR_IRQ_MASK, 32'h7, `AXI_OKAY);
    wr(`ADDR_PWM_DUTY, 32'h80, `AXI_OKAY);
    wr(`ADDR_OUTPUTS, {19'h0, 1'b1, rnd[11:0]}, `AXI_OKAY);
    repeat (20) @(posedge aclk);
    #1 `CHK(dout, 8'h00)
    host.set_en(1'b1);
    host.frame(8, 1'b0);
    #1 `CHK({irq, pwm_oe, relay, dout}, {2'b11, rnd[11:0]})
    rd(`ADDR_IRQ_STATUS, ok(32'h1));
    rd(`ADDR_IRQ_STATUS, ok(32'h0));
    // large variant: a frame right behind another comes too early
    wr(`ADDR_CTRL, 32'h4, `AXI_OKAY);
    host.frame(8, 1'b1);
    host.frame(8, 1'b0);
    rd(`ADDR_IRQ_STATUS, ok(32'h3));
    // small variant: the same spacing now clears the shorter minimum
    wr(`ADDR_CTRL, 32'hc, `AXI_OKAY);
    host.frame(8, 1'b1);
    host.frame(8, 1'b0);
    rd(`ADDR_IRQ_STATUS, ok(32'h1));
    // a part-byte frame with its interrupt masked, then unmasked
    wr(`ADDR_IRQ_MASK, 32'h0, `AXI_OKAY);
    host.frame(7, 1'b0);
    #1 `CHK(irq, 1'b0)
    wr(`ADDR_IRQ_MASK, 32'h7, `AXI_OKAY);
    #1 `CHK(irq, 1'b1)
    rd(`ADDR_IRQ_STATUS, ok(32'h2));
    host.set_en(1'b0);
    host.frame(8, 1'b0);
    rd(`ADDR_IRQ_STATUS, ok(32'h0));
    host.set_en(1'b1);
    // silence with the watchdog off must be harmless; a low-lane write
    // leaves the upper byte of the wait at its reset value
    wstrb <= 4'h1;
    wr(`ADDR_WD_TIMEOUT, 32'h3214, `AXI_OKAY);
    wstrb <= 4'hf;
    rd(`ADDR_WD_TIMEOUT, ok(32'h14));
    repeat (600) @(posedge aclk);
    #1 `CHK(safe, 1'b0)
    wr(`ADDR_CTRL, 32'h7, `AXI_OKAY);
    repeat (3) host.frame(8, 1'b0);
    #1 `CHK(safe, 1'b0)
    for (n = 0; n < 800 && !safe; n++) @(posedge aclk);
    #1 `CHK({safe, retain_seen}, 2'b11)
    `CHK({pwm_oe, pwm_out, dout, relay}, 14'h0)
    rd(`ADDR_STATUS, ok(32'h070b));
    // neither traffic nor writes release the safe state
    host.frame(8, 1'b0);
    wr(`ADDR_OUTPUTS, 32'hfff, `AXI_OKAY);
    rd(`ADDR_IRQ_STATUS, ok(32'h7));
    #1 `CHK({safe, dout}, 9'h100)
    // silent link gives the slow blink: 500 ms half period
    for (n = 0; n < 12000 && !led; n++) @(posedge aclk);
    for (n = 0; n < 12000 && led; n++) @(posedge aclk);
    `CHK(n inside {[9998:10002]}, 1'b1)
    // only a power cycle leaves the safe state, and it forgets settings
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    #1 `CHK({safe, irq, dout, relay, pwm_oe, led}, 16'h0)
    rd(`ADDR_CTRL, ok(32'h4));
    summarize();
  end
endmodule
`default_nettype wire
